// File: hw/pra_remap.sv
/*
 * Parameter assembly remap: modbus pointer/working registers, cip
 * implicit assembly maps, device status and compact alarm member.
 * Assumes requests synchronous to clk_sys, strobes one cycle long,
 * read data is presented in the cycle after the strobe.
 */
// Local design decisions: the address map and the plain strobed port.
// What this block does
// RL1: forty user-chosen parameters via contiguous working registers
// RL2: definition register holds target parameter modbus address
// RL3: working pairs tied to definition pairs at fixed places
// RL4: working read returns pointed parameter's present value
// RL5: working write updates pointed writable parameter
// RL6: default maps analog input value into 240/241
// RL7: single-register write to assembly registers is refused
// RL8: master uses multiple-register writes for assembly
// RL9: factory restore overwrites all assembly maps
// RL10: output assembly defaults to twenty 32-bit members
// RL11: input assembly: status plus twenty members
// RL12: first input member is status, never remapped
// RL13: configured status has only bits 12, 16 set
// RL14: total member count limited to 100, the lesser of 200 and 100
// RL15: standard alarm member carries full alarm code
// RL16: compact alarm packs four states, two bits each
// RL17: packed codes none, low, high, other
// RL18: writing class/instance/attribute remaps a member
// RL19: compact at 71/01/0C, member 14 at 77/02/0D
// RL20: communications object always instance 2
// RL21: explicit address ranges checked, node only devicenet
// RL22: unconnected explicit only, connected refused
// RL23: working register sits 160 above its definition
`timescale 1ns/100ps
`default_nettype none
module pra_remap #(
   parameter int unsigned N_PAIRS = 40,
   parameter int unsigned O2T_N = 20,
   parameter int unsigned T2O_N = 20,
   parameter int unsigned PAR_N = 16
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic factory_rst,
   input wire logic cfg_ok,
   input wire logic is_devnet,
   input wire logic [31:0] ai_pv,
   input wire pra_pkg::pra_alm_t [3:0] alarm,
   input wire pra_pkg::pra_mb_req_t mb,
   input wire pra_pkg::pra_cip_req_t cip,
   input wire pra_pkg::pra_imp_req_t imp,
   output logic [15:0] mb_rdata,
   output logic mb_err,
   output logic [31:0] cip_rdata,
   output logic cip_err,
   output logic [31:0] imp_rdata,
   output logic imp_err,
   output logic [PAR_N-pra_pkg::PAR_RO-1:0][15:0] param_out
);
   // ==========================================================
   // elaboration checks
   localparam int unsigned NREG = 2 * N_PAIRS;
   localparam int unsigned NPW = PAR_N - pra_pkg::PAR_RO;
   localparam int unsigned LIM = pra_pkg::ENIP_MAX < pra_pkg::DNET_MAX ?
      pra_pkg::ENIP_MAX : pra_pkg::DNET_MAX;
   if (NREG > pra_pkg::WORK_OFS || N_PAIRS <= pra_pkg::DEF_AI_IDX / 2 ||
       pra_pkg::WORK_BASE + NREG > pra_pkg::PAR_BASE) begin : g_bad_pairs
      $error("N_PAIRS out of range");
   end
   // RL14
   if (O2T_N + T2O_N + 1 > LIM || T2O_N + 1 > 31 || O2T_N > 31 ||
       O2T_N + 32'(pra_pkg::O2T_ATTR0) > 255) begin : g_bad_asm
      $error("assembly sizes exceed member limit");
   end
   if (PAR_N <= pra_pkg::PAR_RO || PAR_N > 256) begin : g_bad_par
      $error("PAR_N out of range");
   end

   // ==========================================================
   // state
   typedef struct packed {
      logic [NREG-1:0][15:0] def;
      logic [NPW-1:0][15:0] par;
      logic [O2T_N-1:0][23:0] o2t;
      logic [T2O_N-1:0][23:0] t2o;
      logic [15:0] mb_rdata;
      logic mb_err;
      logic [31:0] cip_rdata;
      logic cip_err;
      logic [31:0] imp_rdata;
      logic imp_err;
   } pra_state_t;

   function automatic pra_state_t state_default();
      pra_state_t d;
      d = '0;
      d.def[pra_pkg::DEF_AI_IDX] = pra_pkg::DEF_AI_PTR; // RL6
      d.def[pra_pkg::DEF_AI_IDX + 1] = pra_pkg::DEF_AI_PTR + 16'h0001;
      return d;
   endfunction

   localparam pra_state_t STATE_RST = state_default();

   pra_state_t s;
   pra_state_t next_s;

   // ==========================================================
   // lookups
   // definition and parameter space, no working indirection
   function automatic logic [15:0] base_peek(input logic [15:0] a,
                                             input pra_state_t t,
                                             input logic [31:0] pv);
      int i;
      logic [15:0] r;
      r = '0;
      i = int'(a);
      if (i >= pra_pkg::DEF_BASE && i < pra_pkg::DEF_BASE + NREG) begin
         r = t.def[i - pra_pkg::DEF_BASE];
      end else if (i == pra_pkg::PAR_BASE) begin
         r = pv[15:0];
      end else if (i == pra_pkg::PAR_BASE + 1) begin
         r = pv[31:16];
      end else if (i >= pra_pkg::PAR_BASE + pra_pkg::PAR_RO &&
                   i < pra_pkg::PAR_BASE + PAR_N) begin
         r = t.par[i - pra_pkg::PAR_BASE - pra_pkg::PAR_RO];
      end
      return r;
   endfunction

   function automatic logic [7:0] alm_code(input pra_pkg::pra_alm_t a);
      logic [7:0] r;
      case (a)
         pra_pkg::ALM_STARTUP: r = pra_pkg::ALC_STARTUP;
         pra_pkg::ALM_NONE: r = pra_pkg::ALC_NONE;
         pra_pkg::ALM_BLOCKED: r = pra_pkg::ALC_BLOCKED;
         pra_pkg::ALM_LOW: r = pra_pkg::ALC_LOW;
         pra_pkg::ALM_HIGH: r = pra_pkg::ALC_HIGH;
         default: r = pra_pkg::ALC_ERROR;
      endcase
      return r;
   endfunction

   function automatic logic [1:0] alm_pack(input pra_pkg::pra_alm_t a);
      logic [1:0] r;
      case (a)
         pra_pkg::ALM_NONE: r = pra_pkg::ALP_NONE;
         pra_pkg::ALM_LOW: r = pra_pkg::ALP_LOW;
         pra_pkg::ALM_HIGH: r = pra_pkg::ALP_HIGH;
         default: r = pra_pkg::ALP_OTHER;
      endcase
      return r;
   endfunction

   // value of the parameter a class/instance/attribute selects
   function automatic logic [31:0] member_val(input pra_pkg::pra_cia_t c,
                                              input pra_state_t t,
                                              input logic [31:0] pv,
                                     input pra_pkg::pra_alm_t [3:0] al);
      logic [31:0] r;
      int k;
      r = '0;
      k = int'(c.attr) - 1;
      if (c == pra_pkg::CIA_COMPACT) begin
         for (int j = 0; j < 4; j++) begin
            r[2*j +: 2] = alm_pack(al[j]); // RL16 RL17
         end
      end else if (c == pra_pkg::CIA_AI_PV) begin
         r = pv;
      end else if (c.cls == pra_pkg::ALM_CLASS &&
                   c.attr == pra_pkg::ALM_ATTR &&
                   c.inst >= 8'h01 && c.inst <= 8'h04) begin
         r = {24'h00_0000, alm_code(al[c.inst[1:0] - 2'h1])}; // RL15
      end else if (c.cls == pra_pkg::PAR_CLASS &&
                   c.inst == pra_pkg::PAR_INST && k >= 0 && k < NPW) begin
         r = {16'h0000, t.par[k]};
      end
      return r;
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      int i;
      int tgt;
      int k;
      logic asm_hit;
      logic is_work;
      logic cip_ok;
      logic [15:0] ptr;
      pra_pkg::pra_cia_t c;
      i = 0;
      tgt = 0;
      k = 0;
      asm_hit = 1'b0;
      is_work = 1'b0;
      cip_ok = 1'b0;
      ptr = '0;
      c = '0;
      next_s = s;
      next_s.mb_rdata = '0;
      next_s.mb_err = 1'b0;
      next_s.cip_rdata = '0;
      next_s.cip_err = 1'b0;
      next_s.imp_rdata = '0;
      next_s.imp_err = 1'b0;

      // modbus side
      i = int'(mb.addr);
      is_work = i >= pra_pkg::WORK_BASE && i < pra_pkg::WORK_BASE + NREG;
      asm_hit = is_work ||
         (i >= pra_pkg::DEF_BASE && i < pra_pkg::DEF_BASE + NREG);
      if (is_work) begin
         ptr = s.def[i - pra_pkg::WORK_BASE]; // RL3 RL23
      end
      if (mb.rd) begin
         next_s.mb_rdata = is_work ? base_peek(ptr, s, ai_pv) : // RL4
            base_peek(mb.addr, s, ai_pv);
      end
      if (mb.wr) begin
         tgt = is_work ? int'(ptr) : i;
         if (asm_hit && mb.func != pra_pkg::FN_MULTI) begin
            next_s.mb_err = 1'b1; // RL7 RL8
         end else if (asm_hit && !is_work) begin
            next_s.def[i - pra_pkg::DEF_BASE] = mb.wdata; // RL2
         end else if (tgt >= pra_pkg::PAR_BASE + pra_pkg::PAR_RO &&
                      tgt < pra_pkg::PAR_BASE + PAR_N) begin
            next_s.par[tgt - pra_pkg::PAR_BASE - pra_pkg::PAR_RO] =
               mb.wdata; // RL5 RL1
         end else if (!is_work) begin
            next_s.mb_err = 1'b1;
         end
      end

      // cip explicit side
      cip_ok = !cip.connected && cip.loc.cls != 8'h00 && // RL22 RL21
         cip.loc.attr != 8'h00 &&
         !(is_devnet && cip.node > pra_pkg::NODE_MAX);
      k = int'(cip.loc.attr);
      if (cip.wr) begin
         if (!cip_ok || cip.loc.cls != pra_pkg::COMM_CLASS ||
             cip.loc.inst != pra_pkg::COMM_INST) begin // RL20
            next_s.cip_err = 1'b1;
         end else if (k >= 1 && k <= T2O_N) begin
            next_s.t2o[k - 1] = cip.val; // RL18 RL19 RL12
         end else if (k > int'(pra_pkg::O2T_ATTR0) &&
                      k <= int'(pra_pkg::O2T_ATTR0) + O2T_N) begin
            next_s.o2t[k - int'(pra_pkg::O2T_ATTR0) - 1] = cip.val; // RL18
         end else begin
            next_s.cip_err = 1'b1;
         end
      end
      if (cip.rd) begin
         if (!cip_ok) begin
            next_s.cip_err = 1'b1;
         end else if (cip.loc.cls == pra_pkg::COMM_CLASS &&
                      cip.loc.inst == pra_pkg::COMM_INST) begin
            if (k >= 1 && k <= T2O_N) begin
               next_s.cip_rdata = {8'h00, s.t2o[k - 1]};
            end else if (k > int'(pra_pkg::O2T_ATTR0) &&
                         k <= int'(pra_pkg::O2T_ATTR0) + O2T_N) begin
               next_s.cip_rdata = {8'h00,
                  s.o2t[k - int'(pra_pkg::O2T_ATTR0) - 1]};
            end else begin
               next_s.cip_err = 1'b1;
            end
         end else begin
            next_s.cip_rdata = member_val(cip.loc, s, ai_pv, alarm);
         end
      end

      // implicit side: input members 1..T2O_N+1, output 1..O2T_N
      k = int'(imp.idx);
      if (imp.rd) begin
         if (k == 1) begin
            next_s.imp_rdata = cfg_ok ? pra_pkg::STATUS_OK : // RL12 RL13
               pra_pkg::STATUS_NOCFG;
         end else if (k >= 2 && k <= T2O_N + 1) begin
            next_s.imp_rdata = member_val(s.t2o[k - 2], s, ai_pv, alarm);
         end else begin
            next_s.imp_err = 1'b1; // RL11
         end
      end
      if (imp.wr) begin
         if (k >= 1 && k <= O2T_N) begin
            c = s.o2t[k - 1];
            i = int'(c.attr) - 1;
            if (c.cls == pra_pkg::PAR_CLASS && c.inst == pra_pkg::PAR_INST &&
                i >= 0 && i < NPW) begin
               next_s.par[i] = imp.wdata[15:0]; // RL10
            end
         end else begin
            next_s.imp_err = 1'b1;
         end
      end

      // restore has priority over every map write
      if (factory_rst) begin
         next_s.def = STATE_RST.def; // RL9
         next_s.o2t = STATE_RST.o2t;
         next_s.t2o = STATE_RST.t2o;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         s <= STATE_RST;
      end else begin
         s <= next_s;
      end
   end

   assign mb_rdata = s.mb_rdata;
   assign mb_err = s.mb_err;
   assign cip_rdata = s.cip_rdata;
   assign cip_err = s.cip_err;
   assign imp_rdata = s.imp_rdata;
   assign imp_err = s.imp_err;
   assign param_out = s.par;

   // ==========================================================
   // checks
   logic [7:0] pk;
   always_comb begin
      pk = '0;
      for (int j = 0; j < 4; j++) begin
         case (alarm[j])
            pra_pkg::ALM_NONE: pk[2*j +: 2] = 2'h0;
            pra_pkg::ALM_LOW: pk[2*j +: 2] = 2'h1;
            pra_pkg::ALM_HIGH: pk[2*j +: 2] = 2'h2;
            default: pk[2*j +: 2] = 2'h3;
         endcase
      end
   end

   a_fn06_refused: assert property (@(posedge clk_sys) disable iff (!rstn) // RL7
      mb.wr && mb.func == pra_pkg::FN_SINGLE &&
      mb.addr == 16'h0028 && !factory_rst
      |=> mb_err && $stable(s.def[0]))
      else $error("single write to assembly not refused");

   a_def_store: assert property (@(posedge clk_sys) disable iff (!rstn) // RL2
      mb.wr && mb.func == pra_pkg::FN_MULTI && mb.addr == 16'h0028 &&
      !factory_rst
      |=> !mb_err && s.def[0] == $past(mb.wdata))
      else $error("definition write lost");

   a_work_read: assert property (@(posedge clk_sys) disable iff (!rstn) // RL4
      mb.rd && mb.addr == 16'h00F0 && s.def[40] == pra_pkg::DEF_AI_PTR
      ##1 !mb.rd
      |-> mb_rdata == $past(ai_pv[15:0]) ##1 mb_rdata == 16'h0000)
      else $error("working read not redirected");

   a_work_write: assert property (@(posedge clk_sys) disable iff (!rstn) // RL5
      mb.wr && mb.func == pra_pkg::FN_MULTI && mb.addr == 16'h00C8 &&
      s.def[0] == 16'h016A
      |=> param_out[0] == $past(mb.wdata))
      else $error("working write did not reach parameter");

   a_factory_map: assert property (@(posedge clk_sys) disable iff (!rstn) // RL9
      factory_rst
      |=> s.def[40] == pra_pkg::DEF_AI_PTR &&
          s.def[41] == 16'h0169 && s.t2o == '0 && s.o2t == '0)
      else $error("factory restore incomplete");

   a_status_word: assert property (@(posedge clk_sys) disable iff (!rstn) // RL13
      imp.rd && imp.idx == 5'h01 && cfg_ok
      |=> imp_rdata == 32'h0001_1000 && !imp_err)
      else $error("device status word wrong");

   a_status_locked: assert property (@(posedge clk_sys) disable iff (!rstn) // RL12
      cip.wr && cip.loc.cls == 8'h77 && cip.loc.inst == 8'h02 &&
      cip.loc.attr == 8'h00 && !factory_rst
      |=> cip_err && $stable(s.t2o))
      else $error("status member remap not refused");

   a_compact_pack: assert property (@(posedge clk_sys) disable iff (!rstn) // RL16
      cip.rd && cip.loc == 24'h71010C && !cip.connected &&
      !(is_devnet && cip.node > 8'h3F)
      |=> cip_rdata == {24'h00_0000, $past(pk)})
      else $error("compact alarm packing wrong");

   a_connected_refused: assert property (@(posedge clk_sys) disable iff (!rstn) // RL22
      cip.wr && cip.connected && !factory_rst
      |=> cip_err && $stable(s.t2o) && $stable(s.o2t))
      else $error("connected explicit message accepted");

   a_remap_member14: assert property (@(posedge clk_sys) disable iff (!rstn) // RL19
      cip.wr && !cip.connected && cip.loc == 24'h77020D &&
      cip.val == 24'h71010C && !factory_rst && !(is_devnet && cip.node > 8'h3F)
      |=> s.t2o[12] == 24'h71010C ##0 !cip_err)
      else $error("member 14 remap failed");
endmodule
`default_nettype wire

// File: hw/pra_pkg.sv
/*
 * Shared constants and carrier types of the parameter assembly remap block.
 * Assumes one 25 MHz system clock and an owner that imports nothing.
 */
`default_nettype none
package pra_pkg;
   // ==========================================================
   // modbus address map
   localparam int unsigned DEF_BASE = 40;
   localparam int unsigned WORK_OFS = 160;
   localparam int unsigned WORK_BASE = DEF_BASE + WORK_OFS;
   localparam int unsigned PAR_BASE = 360;
   localparam int unsigned PAR_RO = 2;
   localparam int unsigned DEF_AI_IDX = 40;
   localparam logic [15:0] DEF_AI_PTR = 16'h0168;
   localparam logic [7:0] FN_SINGLE = 8'h06;
   localparam logic [7:0] FN_MULTI = 8'h10;
   // ==========================================================
   // cip addressing
   localparam logic [7:0] COMM_CLASS = 8'h77;
   localparam logic [7:0] COMM_INST = 8'h02;
   localparam logic [7:0] O2T_ATTR0 = 8'h28;
   localparam logic [23:0] CIA_COMPACT = 24'h71010C;
   localparam logic [23:0] CIA_AI_PV = 24'h680101;
   localparam logic [7:0] ALM_CLASS = 8'h6D;
   localparam logic [7:0] ALM_ATTR = 8'h0A;
   localparam logic [7:0] PAR_CLASS = 8'h6A;
   localparam logic [7:0] PAR_INST = 8'h01;
   localparam logic [7:0] NODE_MAX = 8'h3F;
   localparam int unsigned DNET_MAX = 200;
   localparam int unsigned ENIP_MAX = 100;
   localparam logic [31:0] STATUS_OK = 32'h0001_1000;
   localparam logic [31:0] STATUS_NOCFG = 32'h0000_0000;
   // ==========================================================
   // alarm codes
   localparam logic [7:0] ALC_STARTUP = 8'h58;
   localparam logic [7:0] ALC_NONE = 8'h3D;
   localparam logic [7:0] ALC_BLOCKED = 8'h0C;
   localparam logic [7:0] ALC_LOW = 8'h08;
   localparam logic [7:0] ALC_HIGH = 8'h07;
   localparam logic [7:0] ALC_ERROR = 8'h1C;
   localparam logic [1:0] ALP_NONE = 2'h0;
   localparam logic [1:0] ALP_LOW = 2'h1;
   localparam logic [1:0] ALP_HIGH = 2'h2;
   localparam logic [1:0] ALP_OTHER = 2'h3;
   // ==========================================================
   // types
   typedef enum logic [2:0] {
      ALM_STARTUP, ALM_NONE, ALM_BLOCKED, ALM_LOW, ALM_HIGH, ALM_ERROR
   } pra_alm_t;
   typedef struct packed {
      logic [7:0] cls;
      logic [7:0] inst;
      logic [7:0] attr;
   } pra_cia_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] func;
      logic [15:0] addr;
      logic [15:0] wdata;
   } pra_mb_req_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic connected;
      logic [7:0] node;
      pra_cia_t loc;
      pra_cia_t val;
   } pra_cip_req_t;
   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] idx;
      logic [31:0] wdata;
   } pra_imp_req_t;
endpackage
`default_nettype wire

// File: tb/pra_master.sv
/*
 * Fieldbus master model for the remap block: modbus, explicit and
 * implicit request tasks on the package carriers.
 * Assumes one clock; answers stand in the cycle after each strobe.
 */
`timescale 1ns/100ps
`default_nettype none
module pra_master (
   input wire logic clk_sys,
   input wire logic [15:0] mb_rdata,
   input wire logic mb_err,
   input wire logic [31:0] cip_rdata,
   input wire logic cip_err,
   input wire logic [31:0] imp_rdata,
   input wire logic imp_err,
   output var pra_pkg::pra_mb_req_t mb,
   output var pra_pkg::pra_cip_req_t cip,
   output var pra_pkg::pra_imp_req_t imp
);
   // ==========================================================
   // idle bus
   initial begin
      mb = '0;
      cip = '0;
      imp = '0;
   end
   // ==========================================================
   // transfers: one strobe cycle, released fields toggle
   task automatic mb_xfer(input logic wr, input logic [7:0] fn,
         input logic [15:0] a, input logic [15:0] d,
         output logic [15:0] q, output logic e);
      @(posedge clk_sys);
      mb <= '{wr: wr, rd: !wr, func: fn, addr: a, wdata: d};
      @(posedge clk_sys);
      mb <= '{wr: 1'b0, rd: 1'b0, func: ~fn, addr: ~a, wdata: ~d};
      #1;
      q = mb_rdata;
      e = mb_err;
   endtask
   task automatic cip_xfer(input logic wr, input logic con,
         input logic [7:0] nd, input logic [23:0] l, input logic [23:0] v,
         output logic [31:0] q, output logic e);
      @(posedge clk_sys);
      cip <= '{wr: wr, rd: !wr, connected: con, node: nd, loc: l,
         val: v};
      @(posedge clk_sys);
      cip <= '{wr: 1'b0, rd: 1'b0, connected: ~con, node: ~nd, loc: ~l,
         val: ~v};
      #1;
      q = cip_rdata;
      e = cip_err;
   endtask
   task automatic imp_xfer(input logic wr, input logic [4:0] ix,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clk_sys);
      imp <= '{wr: wr, rd: !wr, idx: ix, wdata: d};
      @(posedge clk_sys);
      imp <= '{wr: 1'b0, rd: 1'b0, idx: ~ix, wdata: ~d};
      #1;
      q = imp_rdata;
      e = imp_err;
   endtask
endmodule
`default_nettype wire

// File: tb/pra_remap_test.sv
/*
 * Self-checking bench of the remap block with a fieldbus master model.
 * Assumes the package carriers and the default block parameters.
 */
`timescale 1ns/100ps
`default_nettype none
module pra_remap_test;
   logic clk_sys = 1'b0;
   logic rstn, factory_rst, cfg_ok, is_devnet, e;
   logic [31:0] ai_pv, q32;
   logic [15:0] q16;
   pra_pkg::pra_alm_t [3:0] alarm;
   pra_pkg::pra_mb_req_t mb;
   pra_pkg::pra_cip_req_t cip;
   pra_pkg::pra_imp_req_t imp;
   logic [15:0] mb_rdata;
   logic [31:0] cip_rdata, imp_rdata;
   logic mb_err, cip_err, imp_err;
   logic [13:0][15:0] param_out;
   logic [31:0] seed = 32'h0000_3DD3;
   logic [7:0] alc [6] = '{8'h58, 8'h3D, 8'h0C, 8'h08, 8'h07, 8'h1C};
   int errors = 0;
   int n_checks = 0;
   always #20 clk_sys = ~clk_sys;
   pra_remap DUT (.clk_sys(clk_sys), .rstn(rstn),
      .factory_rst(factory_rst), .cfg_ok(cfg_ok), .is_devnet(is_devnet),
      .ai_pv(ai_pv), .alarm(alarm), .mb(mb), .cip(cip), .imp(imp),
      .mb_rdata(mb_rdata), .mb_err(mb_err), .cip_rdata(cip_rdata),
      .cip_err(cip_err), .imp_rdata(imp_rdata), .imp_err(imp_err),
      .param_out(param_out));
   pra_master m (.clk_sys(clk_sys), .mb_rdata(mb_rdata), .mb_err(mb_err),
      .cip_rdata(cip_rdata), .cip_err(cip_err), .imp_rdata(imp_rdata),
      .imp_err(imp_err), .mb(mb), .cip(cip), .imp(imp));
   // ==========================================================
   // expectations and compares
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] pack(input pra_pkg::pra_alm_t [3:0] al);
      pack = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         pack[2*i +: 2] = (al[i] == pra_pkg::ALM_NONE) ? 2'h0 :
            (al[i] == pra_pkg::ALM_LOW) ? 2'h1 :
            (al[i] == pra_pkg::ALM_HIGH) ? 2'h2 : 2'h3;
      end
   endfunction
   task automatic chkd(input logic [31:0] got, input logic [31:0] x);
      n_checks++;
      if (got !== x) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, x);
      end
   endtask
   task automatic chkf(input logic got, input logic x);
      n_checks++;
      if (got !== x) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, x);
      end
   endtask
   task automatic mw(input logic [7:0] fn, input logic [15:0] a,
         input logic [15:0] d, input logic x);
      m.mb_xfer(1'b1, fn, a, d, q16, e);
      chkf(e, x);
   endtask
   task automatic mr(input logic [15:0] a, input logic [15:0] x);
      m.mb_xfer(1'b0, 8'h03, a, 16'h0000, q16, e);
      chkd({16'h0000, q16}, {16'h0000, x});
   endtask
   task automatic cw(input logic con, input logic dv, input logic [7:0] nd,
         input logic [23:0] l, input logic [23:0] v, input logic x);
      @(posedge clk_sys);
      is_devnet <= dv;
      m.cip_xfer(1'b1, con, nd, l, v, q32, e);
      chkf(e, x);
   endtask
   task automatic cr(input logic [23:0] l, input logic [31:0] x);
      m.cip_xfer(1'b0, 1'b0, 8'h00, l, 24'h000000, q32, e);
      chkd(q32, x);
   endtask
   task automatic ir(input logic [4:0] ix, input logic [31:0] x);
      m.imp_xfer(1'b0, ix, 32'h0000_0000, q32, e);
      chkd(q32, x);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      wrap_up;
   end
   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] v;
      int n, p;
      rstn = 1'b0;
      factory_rst = 1'b0;
      cfg_ok = 1'b0;
      is_devnet = 1'b0;
      ai_pv = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         alarm[i] = pra_pkg::ALM_NONE;
      end
      repeat (4) @(posedge clk_sys);
      rstn <= 1'b1;
      ai_pv <= rnd();
      mr(16'h0050, 16'h0168);
      mr(16'h00F0, ai_pv[15:0]);
      mr(16'h00F1, ai_pv[31:16]);
      $display("test defaults done");
      mw(8'h06, 16'h0028, 16'h016A, 1'b1);
      mr(16'h0028, 16'h0000);
      mw(8'h10, 16'h0028, 16'h016A, 1'b0);
      mr(16'h0028, 16'h016A);
      mw(8'h10, 16'h00C8, 16'hA5C3, 1'b0);
      chkd({16'h0000, param_out[0]}, 32'h0000_A5C3);
      for (int i = 0; i < 10; i++) begin
         n = (i == 0) ? 79 : int'(rnd() % 80);
         p = (i == 1) ? 13 : int'(rnd() % 14);
         v = rnd();
         mw(8'h10, 16'h0028 + 16'(n), 16'h016A + 16'(p), 1'b0);
         mw(8'h10, 16'h00C8 + 16'(n), v[15:0], 1'b0);
         chkd({16'h0000, param_out[p]}, {16'h0000, v[15:0]});
         mr(16'h00C8 + 16'(n), v[15:0]);
      end
      mw(8'h10, 16'h0028, 16'h0168, 1'b0);
      mw(8'h10, 16'h00C8, 16'h5A5A, 1'b0);
      mr(16'h00C8, ai_pv[15:0]);
      mw(8'h10, 16'h0010, 16'h0001, 1'b1);
      $display("test working registers done");
      @(posedge clk_sys);
      cfg_ok <= 1'b1;
      ir(5'h01, (32'h1 << 12) | (32'h1 << 16));
      @(posedge clk_sys);
      cfg_ok <= 1'b0;
      ir(5'h01, 32'h0000_0000);
      cw(1'b0, 1'b0, 8'h00, 24'h770200, 24'h71010C, 1'b1);
      $display("test status done");
      cw(1'b0, 1'b0, 8'h00, 24'h77020D, 24'h71010C, 1'b0);
      cr(24'h77020D, 32'h0071_010C);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys);
         for (int k = 0; k < 4; k++) begin
            alarm[k] <= pra_pkg::pra_alm_t'(rnd() % 6);
         end
         @(posedge clk_sys);
         ir(5'h0E, pack(alarm));
         cr(24'h71010C, pack(alarm));
      end
      cw(1'b0, 1'b0, 8'h00, 24'h770201, 24'h6D010A, 1'b0);
      for (int c = 0; c < 6; c++) begin
         @(posedge clk_sys);
         alarm[0] <= pra_pkg::pra_alm_t'(c);
         ir(5'h02, {24'h000000, alc[c]});
      end
      $display("test alarm members done");
      cw(1'b1, 1'b0, 8'h00, 24'h77020D, 24'h680101, 1'b1);
      cw(1'b0, 1'b0, 8'h00, 24'h00020D, 24'h680101, 1'b1);
      cw(1'b0, 1'b1, 8'h40, 24'h77020D, 24'h680101, 1'b1);
      cw(1'b0, 1'b1, 8'h3F, 24'h77020D, 24'h680101, 1'b0);
      cw(1'b0, 1'b0, 8'h40, 24'h77010D, 24'h6D010A, 1'b1);
      cw(1'b0, 1'b0, 8'h40, 24'h77020D, 24'h680101, 1'b0);
      ir(5'h0E, ai_pv);
      $display("test explicit addressing done");
      cw(1'b0, 1'b0, 8'h00, 24'h770229, 24'h6A0101, 1'b0);
      cw(1'b0, 1'b0, 8'h00, 24'h77023C, 24'h6A010E, 1'b0);
      v = rnd();
      m.imp_xfer(1'b1, 5'h01, v, q32, e);
      chkd({16'h0000, param_out[0]}, {16'h0000, v[15:0]});
      m.imp_xfer(1'b1, 5'h14, ~v, q32, e);
      chkd({16'h0000, param_out[13]}, {16'h0000, ~v[15:0]});
      m.imp_xfer(1'b0, 5'h16, 32'h0000_0000, q32, e);
      chkf(e, 1'b1);
      $display("test output assembly done");
      @(posedge clk_sys);
      factory_rst <= 1'b1;
      @(posedge clk_sys);
      factory_rst <= 1'b0;
      mr(16'h0028, 16'h0000);
      mr(16'h0050, 16'h0168);
      ir(5'h0E, 32'h0000_0000);
      cr(24'h770229, 32'h0000_0000);
      $display("test factory restore done");
      wrap_up;
   end
endmodule
`default_nettype wire
